// >>> rtl/lba_pkg.sv
`default_nettype none
package lba_pkg;
  // register map (index on the plain port, 8-bit address)
  localparam logic [7:0] LBA_OFF_UPPER = 8'h51;
  localparam logic [7:0] LBA_OFF_CAPACITY = 8'h52;
  localparam logic [7:0] LBA_OFF_CLEAR_LEVEL = 8'h50;
  localparam logic [7:0] LBA_OFF_DECAY = 8'h53;
  localparam logic [7:0] LBA_OFF_ACC = 8'h60;
  localparam logic [7:0] LBA_OFF_IRQ_STAT = 8'h61;
  localparam logic [7:0] LBA_OFF_IRQ_MASK = 8'h62;
  // reset values
  localparam logic [7:0] LBA_RST_CAPACITY = 8'h08;
  localparam logic [7:0] LBA_RST_CLEAR_LEVEL = 8'h04;
  localparam logic [7:0] LBA_RST_UPPER = 8'h06;
  localparam logic [1:0] LBA_RST_DECAY = 2'h1;
  localparam logic [1:0] LBA_RST_IRQ_MASK = 2'h0;
  // status / interrupt bit positions
  localparam int LBA_BIT_RAISE = 0;
  localparam int LBA_BIT_CLEAR = 1;
  // observation cycle timing
  localparam int LBA_CLK_MHZ = 100;
  localparam int LBA_CYCLE_MS = 128;
  localparam int LBA_CYCLE_CLKS = LBA_CYCLE_MS * 1000 * LBA_CLK_MHZ;
endpackage : lba_pkg
`default_nettype wire

// >>> rtl/lba_tick.sv
`timescale 1ns/1ns
`default_nettype none
// free-running divider giving one pulse per observation cycle
module lba_tick #(
  parameter int CYCLE_CLKS = lba_pkg::LBA_CYCLE_CLKS
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  logic [31:0] cnt_ff;

  // count up from zero, pulse in the last clock of each cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0;
    end else if (cnt_ff == 32'(CYCLE_CLKS - 1)) begin
      cnt_ff <= 32'h0;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  assign tick = (cnt_ff == 32'(CYCLE_CLKS - 1));
endmodule : lba_tick
`default_nettype wire

// >>> rtl/lba_top.sv
// Operation
// RULE1 - The input is judged once per fixed 128 ms observation cycle.
// RULE2 - Each failed or erratic cycle adds one to the accumulator.
// RULE3 - Each run of 1, 2, 4 or 8 clean cycles, per the decay setting, subtracts one.
// RULE4 - An active alarm clears when the accumulator falls to the clear level.
// RULE5 - The accumulator never exceeds the bucket capacity; failures at the limit change nothing. A lowered capacity cuts the count only at the next tick.
// RULE6 - The alarm is raised at the upper threshold and held until the clear condition, giving hysteresis; raising also needs the count above clear level.
`timescale 1ns/1ns
`default_nettype none
module lba_top #(
  parameter int CYCLE_CLKS = lba_pkg::LBA_CYCLE_CLKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fail_seen,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic alarm,
  output logic irq
);
  import lba_pkg::*;

  logic [7:0] capacity_ff;
  logic [7:0] clear_level_ff;
  logic [7:0] upper_ff;
  logic [1:0] decay_ff;
  logic [1:0] irq_mask_ff;
  logic [1:0] irq_stat_ff;
  logic [7:0] acc_ff;
  logic [7:0] nxt_acc;
  logic [3:0] clean_ff;
  logic [3:0] nxt_clean;
  logic [3:0] run_len;
  logic fail_latch_ff;
  logic alarm_ff;
  logic nxt_alarm;
  logic tick;
  logic raise_ev;
  logic clear_ev;

  // ==========================================================
  // observation cycle
  // ==========================================================
  // one tick per 128 ms cycle [RULE1]
  lba_tick #(.CYCLE_CLKS(CYCLE_CLKS)) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // a fail anywhere in the cycle marks the whole cycle, including at the tick [RULE1]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_latch_ff <= 1'b0;
    end else if (tick) begin
      fail_latch_ff <= 1'b0;
    end else if (fail_seen) begin
      fail_latch_ff <= 1'b1;
    end
  end

  // ==========================================================
  // bucket
  // ==========================================================
  assign run_len = 4'h1 << decay_ff;

  // fill, leak and saturation decided at each tick
  always_comb begin
    nxt_acc = acc_ff;
    nxt_clean = clean_ff;
    if (tick) begin
      if (fail_latch_ff || fail_seen) begin
        nxt_clean = 4'h0; // a bad cycle breaks the clean run [RULE3]
        if (acc_ff < capacity_ff) begin
          nxt_acc = acc_ff + 8'h1; // [RULE2] [RULE5]
        end
      end else if (clean_ff + 4'h1 >= run_len) begin
        nxt_clean = 4'h0;
        if (acc_ff != 8'h0) begin
          nxt_acc = acc_ff - 8'h1; // [RULE3]
        end
      end else begin
        nxt_clean = clean_ff + 4'h1;
      end
      // capacity lowered below the count pulls it down [RULE5]
      if (nxt_acc > capacity_ff) begin
        nxt_acc = capacity_ff;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= 8'h0;
      clean_ff <= 4'h0;
    end else begin
      acc_ff <= nxt_acc;
      clean_ff <= nxt_clean;
    end
  end

  // ==========================================================
  // alarm with hysteresis
  // ==========================================================
  // clear takes priority; raising also needs the count above the clear level,
  // so a clear level at or above upper cannot make the alarm chatter each clock
  always_comb begin
    nxt_alarm = alarm_ff;
    if (alarm_ff && nxt_acc <= clear_level_ff) begin
      nxt_alarm = 1'b0; // [RULE4]
    end else if (!alarm_ff && nxt_acc >= upper_ff && nxt_acc > clear_level_ff) begin
      nxt_alarm = 1'b1; // [RULE6]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_ff <= 1'b0;
    end else begin
      alarm_ff <= nxt_alarm;
    end
  end

  assign alarm = alarm_ff;
  assign raise_ev = nxt_alarm && !alarm_ff;
  assign clear_ev = !nxt_alarm && alarm_ff;

  // ==========================================================
  // registers
  // ==========================================================
  // configuration writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capacity_ff <= LBA_RST_CAPACITY;
      clear_level_ff <= LBA_RST_CLEAR_LEVEL;
      upper_ff <= LBA_RST_UPPER;
      decay_ff <= LBA_RST_DECAY;
      irq_mask_ff <= LBA_RST_IRQ_MASK;
    end else if (reg_wr) begin
      if (reg_addr == LBA_OFF_CAPACITY) begin
        capacity_ff <= reg_wdata;
      end else if (reg_addr == LBA_OFF_CLEAR_LEVEL) begin
        clear_level_ff <= reg_wdata;
      end else if (reg_addr == LBA_OFF_UPPER) begin
        upper_ff <= reg_wdata;
      end else if (reg_addr == LBA_OFF_DECAY) begin
        decay_ff <= reg_wdata[1:0];
      end else if (reg_addr == LBA_OFF_IRQ_MASK) begin
        irq_mask_ff <= reg_wdata[1:0];
      end
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == LBA_BIT_RAISE && raise_ev) || (i == LBA_BIT_CLEAR && clear_ev)) begin
          irq_stat_ff[i] <= 1'b1;
        end else if (reg_wr && reg_addr == LBA_OFF_IRQ_STAT && reg_wdata[i]) begin
          irq_stat_ff[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h0;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h0;
    end else if (reg_addr == LBA_OFF_CAPACITY) begin
      reg_rdata <= capacity_ff;
    end else if (reg_addr == LBA_OFF_CLEAR_LEVEL) begin
      reg_rdata <= clear_level_ff;
    end else if (reg_addr == LBA_OFF_UPPER) begin
      reg_rdata <= upper_ff;
    end else if (reg_addr == LBA_OFF_DECAY) begin
      reg_rdata <= {6'h0, decay_ff};
    end else if (reg_addr == LBA_OFF_ACC) begin
      reg_rdata <= acc_ff;
    end else if (reg_addr == LBA_OFF_IRQ_STAT) begin
      reg_rdata <= {6'h0, irq_stat_ff};
    end else if (reg_addr == LBA_OFF_IRQ_MASK) begin
      reg_rdata <= {6'h0, irq_mask_ff};
    end else begin
      reg_rdata <= 8'h0;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  a_acc_capped: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    tick |=> acc_ff <= $past(capacity_ff))
    else $error("accumulator above capacity");
  a_acc_fill: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
    tick && fail_seen && acc_ff < capacity_ff && !(reg_wr && reg_addr == LBA_OFF_CAPACITY)
    |=> acc_ff == $past(acc_ff) + 8'h1)
    else $error("failed cycle did not fill");
  a_acc_quiet: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
    !tick && !(reg_wr) |=> acc_ff == $past(acc_ff))
    else $error("accumulator moved between ticks");
  a_acc_leak: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
    tick && !fail_seen && !fail_latch_ff && decay_ff == 2'h0 && acc_ff != 8'h0
    && acc_ff <= capacity_ff |=> acc_ff == $past(acc_ff) - 8'h1)
    else $error("clean cycle did not leak");
  a_alarm_clear: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    alarm_ff && nxt_acc <= clear_level_ff |=> !alarm_ff)
    else $error("alarm not cleared at clear level");
  a_alarm_raise: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
    !alarm_ff && nxt_acc >= upper_ff && nxt_acc > clear_level_ff |=> alarm_ff)
    else $error("alarm not raised at upper level");
  a_stat_raise_kept: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
    raise_ev |=> irq_stat_ff[LBA_BIT_RAISE])
    else $error("alarm raise not recorded in status");
endmodule : lba_top
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// compare one value, count it, report a mismatch at once
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  import lba_pkg::*;
  localparam int CYC = 16;
  logic clk = 0, rst_n = 0, fail_seen = 0, reg_wr = 0, reg_rd = 0, alarm, irq;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, a0, a1;
  int err_count = 0, checks = 0, cyc = 0;
  lba_top #(.CYCLE_CLKS(CYC)) dut_u (.clk(clk), .rst_n(rst_n), .fail_seen(fail_seen), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alarm(alarm), .irq(irq));
  // ==========
  // clock, and a hang guard well beyond the ~580 cycles needed
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end
  // ==========
  // bus cycles: one-cycle strobes, read data the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // ==========
  // reset values, and an unmapped place that must read zero
  task automatic t_reset;
    rd(LBA_OFF_CAPACITY, a0); `CHK(a0, 8'h08)
    rd(LBA_OFF_CLEAR_LEVEL, a0); `CHK(a0, 8'h04)
    rd(LBA_OFF_UPPER, a0); `CHK(a0, LBA_RST_UPPER)
    rd(LBA_OFF_DECAY, a0); `CHK(a0, 8'h01)
    rd(LBA_OFF_ACC, a0); `CHK(a0, 8'h00)
    wr(8'h70, 8'hA5);
    rd(8'h70, a0); `CHK(a0, 8'h00)
  endtask : t_reset
  // ==========
  // failing input: one step per cycle, then pinned at capacity
  task automatic t_fill;
    wr(LBA_OFF_IRQ_MASK, 8'h03);
    fail_seen <= 1'b1;
    repeat (CYC) @(posedge clk);
    rd(LBA_OFF_ACC, a0); `CHK(a0, 8'h01)
    repeat (CYC - 2) @(posedge clk);
    rd(LBA_OFF_ACC, a1); `CHK(a1, a0 + 8'h01)
    `CHK(a1, 8'h02)
    repeat (12 * CYC) @(posedge clk);
    rd(LBA_OFF_ACC, a1); `CHK(a1, 8'h08)
    `CHK(alarm, 1'b1)
    rd(LBA_OFF_IRQ_STAT, a0); `CHK(a0[0], 1'b1)
    `CHK(irq, 1'b1)
    wr(LBA_OFF_IRQ_STAT, 8'h01);
    #1 `CHK(irq, 1'b0)
  endtask : t_fill
  // ==========
  // clean input: one step down per 1, 2, 4, 8 cycles; alarm drops at 4
  task automatic t_decay;
    // inputs only move on a rising edge
    @(posedge clk);
    fail_seen <= 1'b0;
    // the partial cycle still counts as failed, so let it finish
    repeat (CYC) @(posedge clk);
    for (int d = 0; d < 4; d++) begin
      wr(LBA_OFF_DECAY, 8'(d));
      rd(LBA_OFF_ACC, a0); `CHK(a0, 8'h08 - 8'(d))
      repeat ((CYC << d) - 2) @(posedge clk);
      rd(LBA_OFF_ACC, a1); `CHK(a1, a0 - 8'h01)
    end
    `CHK(a1, 8'h04)
    `CHK(alarm, 1'b0)
    rd(LBA_OFF_IRQ_STAT, a0); `CHK(a0[1:0], 2'h2)
    `CHK(irq, 1'b1)
    wr(LBA_OFF_IRQ_MASK, 8'h00);
    #1 `CHK(irq, 1'b0)
  endtask : t_decay
  // ==========
  // lowered limits: count pulled down to a new capacity, alarm at a new upper
  task automatic t_limits;
    wr(LBA_OFF_CAPACITY, 8'h03);
    fail_seen <= 1'b1;
    rd(LBA_OFF_CAPACITY, a0); `CHK(a0, 8'h03)
    repeat (CYC) @(posedge clk);
    rd(LBA_OFF_ACC, a1); `CHK(a1, 8'h03)
    `CHK(alarm, 1'b0)
    wr(LBA_OFF_CLEAR_LEVEL, 8'h01);
    wr(LBA_OFF_UPPER, 8'h02);
    rd(LBA_OFF_CLEAR_LEVEL, a0); `CHK(a0, 8'h01)
    rd(LBA_OFF_UPPER, a0); `CHK(a0, 8'h02)
    repeat (CYC) @(posedge clk);
    `CHK(alarm, 1'b1)
    `CHK(irq, 1'b0)
    rd(LBA_OFF_ACC, a1); `CHK(a1, 8'h03)
  endtask : t_limits
  // ==========
  task automatic results;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  // ==========
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_fill();
    t_decay();
    t_limits();
    results();
  end
endmodule : tb_top
`default_nettype wire
